// ### summary_status_pkg.sv
// Package: widths, bit positions, reset values and types for the summary status registers
package summary_status_pkg;

	// ==========================================
	// Register geometry
	localparam int unsigned REG_WIDTH = 16;
	localparam int unsigned DEC_DIGITS = 5;
	localparam int unsigned PARENT_BIT = 1;
	localparam int unsigned OUTPUT_BIT = 0;
	localparam int unsigned OVERFLOW_BIT = 11;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	localparam logic [15:0] EVENT_RESET = 16'h0000;
	localparam logic [15:0] OUT_OVF_WEIGHT = 16'h0801;

	// ==========================================
	// Carriers
	typedef logic [15:0] reg16_t;

	// Decimal answer, one BCD digit per nibble, most significant first
	typedef struct packed {
		logic [3:0] d4;
		logic [3:0] d3;
		logic [3:0] d2;
		logic [3:0] d1;
		logic [3:0] d0;
	} bcd5_t;

	typedef enum logic [1:0] {
		MASK_RADIX_DEC,
		MASK_RADIX_BIN,
		MASK_RADIX_HEX
	} mask_radix_t;

endpackage

// ### instrument_summary_status_regs.sv
// Module: summary event register, enable mask and summary flag toward the parent register
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - An event-register read returns current contents, then clears all bits but those rising in the read cycle.
// - Read answer is the decimal form of the bit-weighted sum.
// - Mask writable and readable, resets to zero, never part of saved setups.
// - Any set event bit with its mask bit set raises parent bit 1.
// - Output and reading-overflow conditions sit at bits 0 and 11, weight 2049.
// - Enabled instrument events set the summary flag of the measurement register.
module instrument_summary_status_regs
	import summary_status_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Condition inputs from the instrument
	input  wire reg16_t      cond_in,
	input  wire logic        output_cond,
	input  wire logic        overflow_cond,
	// Event register query
	input  wire logic        event_rd,
	output logic             event_rd_valid,
	output var reg16_t       event_value,
	output var bcd5_t        event_decimal,
	// Mask access, value already converted from its radix by the parser
	input  wire logic        mask_wr,
	input  wire mask_radix_t mask_radix,
	input  wire reg16_t      mask_wdata,
	output var reg16_t       mask_value,
	// Summary toward the parent register
	output logic             meas_inst_summary_event_reg,
	output logic             instrument_summary_flag
);

	// ==========================================
	// Binary to BCD by double dabble; used for every read answer
	function automatic bcd5_t to_decimal(input reg16_t v);
		logic [19:0] acc;
		acc = 20'h0_0000;
		for (int i = int'(REG_WIDTH) - 1; i >= 0; i--) begin
			for (int k = 0; k < int'(DEC_DIGITS); k++) begin
				if (acc[k*4 +: 4] > 4'h4) begin
					acc[k*4 +: 4] = acc[k*4 +: 4] + 4'h3;
				end
			end
			acc = {acc[18:0], v[i]};
		end
		return bcd5_t'(acc);
	endfunction

	// Digit weights rebuild a decimal answer; checks use it apart from the double dabble
	function automatic logic [19:0] decimal_weight(input bcd5_t b);
		return 20'(b.d4) * 20'h0_2710 + 20'(b.d3) * 20'h0_03E8
			+ 20'(b.d2) * 20'h0_0064 + 20'(b.d1) * 20'h0_000A + 20'(b.d0);
	endfunction

	// ==========================================
	// Conditions and edge detection
	reg16_t cond_all;
	reg16_t cond_q;
	reg16_t rise;
	reg16_t event_q;
	reg16_t event_d;
	reg16_t mask_q;
	reg16_t mask_d;
	logic   summary;

	// Dedicated conditions forced onto their fixed positions
	always_comb begin
		cond_all = cond_in;
		cond_all[OUTPUT_BIT] = cond_in[OUTPUT_BIT] | output_cond;
		cond_all[OVERFLOW_BIT] = cond_in[OVERFLOW_BIT] | overflow_cond;
	end

	assign rise = cond_all & ~cond_q;
	// A rising edge in the read cycle survives the clear, so no event is lost
	assign event_d = (event_rd ? EVENT_RESET : event_q) | rise;
	// Radix only matters to the parser; the value arrives already binary
	assign mask_d = mask_wr ? mask_wdata : mask_q;
	assign summary = |(event_q & mask_q);

	// Registers; mask lives only in flops, so it is lost on power cycle
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cond_q <= EVENT_RESET;
			event_q <= EVENT_RESET;
			mask_q <= MASK_RESET;
		end else begin
			cond_q <= cond_all;
			event_q <= event_d;
			mask_q <= mask_d;
		end
	end

	// Read answer captured from the contents before the clear
	always_ff @(posedge clk) begin
		if (!resetn) begin
			event_rd_valid <= 1'b0;
			event_value <= EVENT_RESET;
			event_decimal <= bcd5_t'(20'h0_0000);
			meas_inst_summary_event_reg <= 1'b0;
		end else begin
			event_rd_valid <= event_rd;
			meas_inst_summary_event_reg <= summary;
			if (event_rd) begin
				event_value <= event_q;
				event_decimal <= to_decimal(event_q);
			end
		end
	end

	assign mask_value = mask_q;
	assign instrument_summary_flag = meas_inst_summary_event_reg;

	// ==========================================
	// Checks on the read path
	// Contents vanish after a read unless a condition rose in that very cycle
	read_clears_a: assert property (@(posedge clk) disable iff (!resetn)
		event_rd && !(|rise) |=> event_q == EVENT_RESET)
		else $error("event register not cleared by read");

	// The answer is the snapshot taken at the read edge
	read_value_a: assert property (@(posedge clk) disable iff (!resetn)
		event_rd |=> event_rd_valid && event_value == $past(event_q))
		else $error("read answer differs from contents");

	// No answer pulse without a query one cycle earlier
	valid_only_a: assert property (@(posedge clk) disable iff (!resetn)
		!event_rd |=> !event_rd_valid)
		else $error("answer pulse without a query");

	// The host may collect the answer late, so it must not drift between reads
	value_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		!event_rd |=> $stable(event_value) && $stable(event_decimal))
		else $error("read answer changed between reads");

	// Rebuilt from digit weights, so a conversion slip cannot hide behind itself
	decimal_a: assert property (@(posedge clk) disable iff (!resetn)
		event_rd_valid |-> decimal_weight(event_decimal) == {4'h0, event_value})
		else $error("decimal answer wrong");

	// Every digit of the answer is a legal decimal digit
	bcd_digits_a: assert property (@(posedge clk) disable iff (!resetn)
		event_rd_valid |-> event_decimal.d4 <= 4'h9 && event_decimal.d3 <= 4'h9
			&& event_decimal.d2 <= 4'h9 && event_decimal.d1 <= 4'h9
			&& event_decimal.d0 <= 4'h9)
		else $error("decimal digit out of range");

	// ==========================================
	// Checks on the enable mask
	// A write lands in the next cycle
	mask_write_a: assert property (@(posedge clk) disable iff (!resetn)
		mask_wr |=> mask_value == $past(mask_wdata))
		else $error("mask write lost");

	// Without a write the mask keeps its value
	mask_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		!mask_wr |=> $stable(mask_value))
		else $error("mask changed without write");

	// Mask starts from zero after every reset, the power-cycle case included
	mask_reset_a: assert property (@(posedge clk)
		!resetn |=> mask_value == MASK_RESET)
		else $error("mask not cleared by reset");

	// ==========================================
	// Checks on the summary toward the parent register
	// An enabled event raises the parent bit one cycle later
	parent_bit_a: assert property (@(posedge clk) disable iff (!resetn)
		|(event_q & mask_q) |=> meas_inst_summary_event_reg)
		else $error("parent bit not raised");

	// No enabled event, no parent bit
	parent_low_a: assert property (@(posedge clk) disable iff (!resetn)
		!(|(event_q & mask_q)) |=> !instrument_summary_flag)
		else $error("parent bit raised without enabled event");

	// Summary flag follows any enabled event as well
	flag_raise_a: assert property (@(posedge clk) disable iff (!resetn)
		|(event_q & mask_q) |=> instrument_summary_flag)
		else $error("summary flag not raised");

	// Reset leaves no stale summary or answer pulse behind
	summary_reset_a: assert property (@(posedge clk)
		!resetn |=> !meas_inst_summary_event_reg && !event_rd_valid)
		else $error("summary or answer pulse active after reset");

	// ==========================================
	// Checks on the fixed condition positions
	// Gated by the sampled reset: at the release edge the flops still take their reset values
	overflow_pos_a: assert property (@(posedge clk) disable iff (!resetn)
		resetn && overflow_cond && !cond_q[OVERFLOW_BIT] |=> event_q[OVERFLOW_BIT])
		else $error("overflow not at its fixed bit");

	output_pos_a: assert property (@(posedge clk) disable iff (!resetn)
		resetn && output_cond && !cond_q[OUTPUT_BIT] |=> event_q[OUTPUT_BIT])
		else $error("output condition not at its fixed bit");

	// ==========================================
	// Checks on event latching
	// One sample bit that must survive until read
	latch_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		event_q[3] && !event_rd |=> event_q[3])
		else $error("event bit dropped without read");

	// Every rising condition lands in the register
	latch_all_a: assert property (@(posedge clk) disable iff (!resetn)
		resetn && |rise |=> (event_q & $past(rise)) == $past(rise))
		else $error("rising condition not latched");

	// No bit of any position drops without a read
	hold_all_a: assert property (@(posedge clk) disable iff (!resetn)
		!event_rd |=> (event_q & $past(event_q)) == $past(event_q))
		else $error("event bits dropped without read");

	// After a read only the bits that rose in the read cycle remain
	read_race_a: assert property (@(posedge clk) disable iff (!resetn)
		event_rd |=> event_q == $past(rise))
		else $error("read cleared a bit rising in the read cycle");

	// ==========================================
	// Main scenarios
	cover_read_c: cover property (@(posedge clk) disable iff (!resetn)
		event_rd && event_q == OUT_OVF_WEIGHT);
	cover_summary_c: cover property (@(posedge clk) disable iff (!resetn)
		$rose(instrument_summary_flag));
	cover_race_c: cover property (@(posedge clk) disable iff (!resetn)
		event_rd && |rise);
	cover_radix_c: cover property (@(posedge clk) disable iff (!resetn)
		mask_wr && mask_radix == MASK_RADIX_DEC);
	cover_release_c: cover property (@(posedge clk) disable iff (!resetn)
		$rose(resetn) ##1 event_q[OUTPUT_BIT]);

endmodule

`default_nettype wire

// ### host_model.sv
// Host side model issuing status queries and mask writes
`timescale 1ns/1ps
`default_nettype none
module host_model
	import summary_status_pkg::*;
(
	// Bench requests
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       rd_req,
	input  wire logic       wr_req,
	input  wire reg16_t     wr_val,
	// Toward the block
	output var mask_radix_t mask_radix,
	output var logic        event_rd,
	output var logic        mask_wr,
	output var reg16_t      mask_wdata
);
	// Idle data toggles so a stale value is never mistaken for a write
	always @(posedge clk) begin
		if (!resetn) begin
			event_rd   <= 1'b0;
			mask_wr    <= 1'b0;
			mask_wdata <= 16'h0000;
			mask_radix <= MASK_RADIX_DEC;
		end else begin
			event_rd   <= rd_req;
			mask_wr    <= wr_req;
			mask_wdata <= wr_req ? wr_val : ~mask_wdata;
			// Each write takes the next prefix form, so all three get used
			if (wr_req) begin
				case (mask_radix)
					MASK_RADIX_DEC: mask_radix <= MASK_RADIX_BIN;
					MASK_RADIX_BIN: mask_radix <= MASK_RADIX_HEX;
					default:        mask_radix <= MASK_RADIX_DEC;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ### tb_top.sv
// Testbench for the summary status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
	import summary_status_pkg::*;
	logic clk = 0, resetn = 0, rd_req = 0, wr_req = 0, oc = 0, ovf = 0;
	logic vld, sum, flag, rd, wr;
	reg16_t wv = '0, cin = '0, val, mv, wd, v, m, ex;
	bcd5_t dec;
	mask_radix_t rx;
	reg16_t notes[$];
	int mismatches = 0, n_checks = 0, cyc = 0;
	always #2 clk = ~clk;
	host_model host (.clk(clk), .resetn(resetn), .rd_req(rd_req), .wr_req(wr_req),
		.wr_val(wv), .mask_radix(rx), .event_rd(rd), .mask_wr(wr), .mask_wdata(wd));
	instrument_summary_status_regs dut (.clk(clk), .resetn(resetn), .cond_in(cin),
		.output_cond(oc), .overflow_cond(ovf), .event_rd(rd), .event_rd_valid(vld),
		.event_value(val), .event_decimal(dec), .mask_wr(wr), .mask_radix(rx),
		.mask_wdata(wd), .mask_value(mv), .meas_inst_summary_event_reg(sum),
		.instrument_summary_flag(flag));
	// ==========================================
	// Helpers
	function automatic bcd5_t to_bcd(input reg16_t x);
		int n;
		n = x;
		return {4'(n/10000), 4'(n/1000%10), 4'(n/100%10), 4'(n/10%10), 4'(n%10)};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic rdq(input reg16_t e);
		rd_req <= 1'b1;
		notes.push_back(e);
		tick(1);
		rd_req <= 1'b0;
		tick(5);
	endtask
	task automatic wrm(input reg16_t x);
		wr_req <= 1'b1;
		wv <= x;
		tick(1);
		wr_req <= 1'b0;
		tick(3);
		`CHK("mask", x, mv)
	endtask
	task automatic end_of_test;
		if (mismatches == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Monitor: each answer takes the oldest note
	always @(posedge clk) begin
		if (vld === 1'b1) begin
			`CHK("note", 1'b1, notes.size() > 0)
			ex = notes.pop_front();
			`CHK("value", ex, val)
			`CHK("decimal", to_bcd(ex), dec)
		end
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			end_of_test;
		end
	end
	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(64842));
		tick(16);
		resetn <= 1'b1;
		tick(2);
		`CHK("mask_rst", 16'h0000, mv)
		`CHK("flag_rst", 1'b0, flag)
		`CHK("vld_rst", 1'b0, vld)
		wrm(16'h0801);
		oc <= 1'b1;
		tick(3);
		`CHK("flag", 1'b1, flag)
		ovf <= 1'b1;
		rdq(16'h0801);
		rdq(16'h0000);
		`CHK("sum_clr", 1'b0, sum)
		{oc, ovf} <= 2'b00;
		for (int i = 0; i < 10; i++) begin
			v = 16'($urandom);
			m = 16'($urandom);
			wrm(m);
			cin <= v;
			tick(1);
			cin <= '0;
			tick(3);
			`CHK("sum", |(v & m), sum)
			rdq(v);
			rdq(16'h0000);
		end
		// Set wins: a condition rising in the read cycle survives the clear
		v = 16'($urandom);
		rd_req <= 1'b1;
		notes.push_back(16'h0000);
		tick(1);
		rd_req <= 1'b0;
		cin <= v;
		tick(1);
		cin <= '0;
		tick(4);
		rdq(v);
		rdq(16'h0000);
		// Mid-run reset: mask back to zero, a high condition latches at release
		wrm(16'h0801);
		resetn <= 1'b0;
		oc <= 1'b1;
		tick(3);
		resetn <= 1'b1;
		tick(2);
		`CHK("mask_rst2", 16'h0000, mv)
		`CHK("flag_rst2", 1'b0, flag)
		rdq(16'h0001);
		oc <= 1'b0;
		rdq(16'h0000);
		`CHK("notes_left", 0, notes.size())
		tick(2);
		end_of_test;
	end
endmodule
`default_nettype wire
